/* File: pll_output_config_decode.sv */
// Purpose: Decode of PLL feedback and clock output configuration words.
// Assumes: Words are written whole on a plain register port.
// Notes: Analog blocks are modelled only by the control values sent to them.
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module pll_output_config_decode #(
    parameter int OUT_N = pll_cfg_pkg::OUT_N,
    parameter int CAL_CYCLES = pll_cfg_pkg::CAL_CYCLES
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [pll_cfg_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [pll_cfg_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [pll_cfg_pkg::DATA_W-1:0] reg_rdata,
    input wire logic global_output_gate_pin,
    output logic [OUT_N-1:0] clock_output_en,
    output logic vco_tap_en,
    output logic [pll_cfg_pkg::FB_W-1:0] feedback_div,
    output logic [pll_cfg_pkg::POST_W-1:0] post_div,
    output logic [21:0] total_feedback_div,
    output logic [5:0] pump_gain_mult,
    output logic cal_start,
    output logic cal_busy
);
    localparam int FB_W = pll_cfg_pkg::FB_W;
    localparam int POST_W = pll_cfg_pkg::POST_W;
    localparam int GAIN_W = pll_cfg_pkg::GAIN_W;
    localparam int DW = pll_cfg_pkg::DATA_W;

    // Stored configuration fields.
    logic [OUT_N-1:0] per_output_enable_q;
    logic [OUT_N-1:0] per_output_enable_d;
    logic global_output_enable_q;
    logic global_output_enable_d;
    logic tap_en_q;
    logic tap_en_d;
    logic [FB_W-1:0] fb_div_q;
    logic [FB_W-1:0] fb_div_d;
    logic [POST_W-1:0] post_div_q;
    logic [POST_W-1:0] post_div_d;
    logic [GAIN_W-1:0] pump_gain_select_q;
    logic [GAIN_W-1:0] pump_gain_select_d;
    logic fb_bad_q;
    logic fb_bad_d;
    logic post_bad_q;
    logic post_bad_d;
    logic [FB_W-1:0] fb_eff_q;
    logic [FB_W-1:0] fb_eff_d;
    logic [POST_W-1:0] post_eff_q;
    logic [POST_W-1:0] post_eff_d;

    // Output registers.
    logic [DW-1:0] rdata_d;
    logic [OUT_N-1:0] clk_en_d;
    logic tap_out_d;
    logic [21:0] total_d;
    logic [5:0] mult_d;
    logic cal_start_d;

    logic gate_sync;
    logic busy;
    logic wr_out;
    logic wr_fb;
    logic [FB_W-1:0] w_fb;
    logic [POST_W-1:0] w_post;

    // The gate pin is asynchronous to sys_clk.
    pin_sync u_gate_sync (
        .sys_clk(sys_clk),
        .srst(srst),
        .pin_async(global_output_gate_pin),
        .pin_sync_q(gate_sync)
    );

    cal_timer #(
        .CYCLES(CAL_CYCLES)
    ) u_cal_timer (
        .sys_clk(sys_clk),
        .srst(srst),
        .start(cal_start_d),
        .busy_q(busy)
    );

    always_comb begin
        wr_out = reg_write && (reg_addr == pll_cfg_pkg::OFF_OUTPUT_CTRL);
        wr_fb = reg_write && (reg_addr == pll_cfg_pkg::OFF_FEEDBACK);
        w_fb = reg_wdata[pll_cfg_pkg::POS_FB_DIV +: FB_W];
        w_post = reg_wdata[pll_cfg_pkg::POS_POST_DIV +: POST_W];
        per_output_enable_d = per_output_enable_q;
        global_output_enable_d = global_output_enable_q;
        tap_en_d = tap_en_q;
        fb_div_d = fb_div_q;
        post_div_d = post_div_q;
        pump_gain_select_d = pump_gain_select_q;
        fb_bad_d = fb_bad_q;
        post_bad_d = post_bad_q;
        fb_eff_d = fb_eff_q;
        post_eff_d = post_eff_q;
        cal_start_d = 1'b0;
        // Whole words only; the port never presents a partial word.
        if (wr_out) begin
            per_output_enable_d =
                reg_wdata[pll_cfg_pkg::POS_PER_EN +: OUT_N];
            global_output_enable_d =
                reg_wdata[pll_cfg_pkg::POS_GLOBAL_EN];
            tap_en_d = reg_wdata[pll_cfg_pkg::POS_TAP_EN];
        end
        if (wr_fb) begin
            fb_div_d = w_fb;
            post_div_d = w_post;
            pump_gain_select_d = reg_wdata[pll_cfg_pkg::POS_GAIN +: GAIN_W];
            cal_start_d = 1'b1;
            // A bad code keeps the last good divider so the counter
            // never runs with an undefined modulus.
            fb_bad_d = (w_fb == pll_cfg_pkg::FB_DIV_ZERO);
            if (!fb_bad_d) begin
                fb_eff_d = w_fb;
            end
            post_bad_d = (w_post < pll_cfg_pkg::POST_DIV_MIN) ||
                (w_post > pll_cfg_pkg::POST_DIV_MAX);
            if (!post_bad_d) begin
                post_eff_d = w_post;
            end
        end
    end

    always_comb begin
        // Global enable and gate pin override every per-output enable.
        for (int i = 0; i < OUT_N; i++) begin
            clk_en_d[i] = per_output_enable_d[i]
                && global_output_enable_d
                && gate_sync;
        end
        tap_out_d = tap_en_d;
        // The post-divider has no bypass setting, so it always multiplies.
        total_d = 22'(fb_eff_d) * 22'(post_eff_d);
        unique case (pump_gain_select_d)
            pll_cfg_pkg::GAIN_X1: mult_d = pll_cfg_pkg::MULT_X1;
            pll_cfg_pkg::GAIN_X4: mult_d = pll_cfg_pkg::MULT_X4;
            pll_cfg_pkg::GAIN_X16: mult_d = pll_cfg_pkg::MULT_X16;
            default: mult_d = pll_cfg_pkg::MULT_X32;
        endcase
        rdata_d = '0;
        if (reg_read) begin
            unique case (reg_addr)
                pll_cfg_pkg::OFF_OUTPUT_CTRL: begin
                    rdata_d[pll_cfg_pkg::POS_PER_EN +: OUT_N] =
                        per_output_enable_q;
                    rdata_d[pll_cfg_pkg::POS_GLOBAL_EN] =
                        global_output_enable_q;
                    rdata_d[pll_cfg_pkg::POS_TAP_EN] = tap_en_q;
                end
                pll_cfg_pkg::OFF_FEEDBACK: begin
                    rdata_d[pll_cfg_pkg::POS_FB_DIV +: FB_W] = fb_div_q;
                    rdata_d[pll_cfg_pkg::POS_POST_DIV +: POST_W] = post_div_q;
                    rdata_d[pll_cfg_pkg::POS_GAIN +: GAIN_W] =
                        pump_gain_select_q;
                end
                pll_cfg_pkg::OFF_STATUS: begin
                    rdata_d[pll_cfg_pkg::POS_ST_CAL] = busy;
                    rdata_d[pll_cfg_pkg::POS_ST_FB_BAD] = fb_bad_q;
                    rdata_d[pll_cfg_pkg::POS_ST_POST_BAD] = post_bad_q;
                    rdata_d[pll_cfg_pkg::POS_ST_GATE] = gate_sync;
                end
                pll_cfg_pkg::OFF_DIVISION: begin
                    rdata_d[21:0] = total_feedback_div;
                end
                default: rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            per_output_enable_q <= pll_cfg_pkg::PER_EN_RST[OUT_N-1:0];
            global_output_enable_q <= pll_cfg_pkg::GLOBAL_EN_RST;
            tap_en_q <= pll_cfg_pkg::TAP_EN_RST;
            fb_div_q <= pll_cfg_pkg::FB_DIV_RST;
            post_div_q <= pll_cfg_pkg::POST_DIV_RST;
            pump_gain_select_q <= pll_cfg_pkg::GAIN_RST;
            fb_bad_q <= 1'b0;
            post_bad_q <= 1'b0;
            fb_eff_q <= pll_cfg_pkg::FB_DIV_RST;
            post_eff_q <= pll_cfg_pkg::POST_DIV_RST;
            reg_rdata <= '0;
            clock_output_en <= '0;
            vco_tap_en <= pll_cfg_pkg::TAP_EN_RST;
            feedback_div <= pll_cfg_pkg::FB_DIV_RST;
            post_div <= pll_cfg_pkg::POST_DIV_RST;
            total_feedback_div <= 22'(pll_cfg_pkg::FB_DIV_RST) *
                22'(pll_cfg_pkg::POST_DIV_RST);
            pump_gain_mult <= pll_cfg_pkg::MULT_X1;
            cal_start <= 1'b0;
            cal_busy <= 1'b0;
        end else begin
            per_output_enable_q <= per_output_enable_d;
            global_output_enable_q <= global_output_enable_d;
            tap_en_q <= tap_en_d;
            fb_div_q <= fb_div_d;
            post_div_q <= post_div_d;
            pump_gain_select_q <= pump_gain_select_d;
            fb_bad_q <= fb_bad_d;
            post_bad_q <= post_bad_d;
            fb_eff_q <= fb_eff_d;
            post_eff_q <= post_eff_d;
            reg_rdata <= rdata_d;
            clock_output_en <= clk_en_d;
            vco_tap_en <= tap_out_d;
            feedback_div <= fb_eff_d;
            post_div <= post_eff_d;
            total_feedback_div <= total_d;
            pump_gain_mult <= mult_d;
            cal_start <= cal_start_d;
            cal_busy <= busy;
        end
    end
endmodule // pll_output_config_decode
`default_nettype wire

/* File: pll_cfg_pkg.sv */
// Purpose: Constants shared by the PLL and output configuration decode block.
// Assumes: Configuration words arrive over a plain register port.
// Notes: Offsets are word indexes on the register port.
package pll_cfg_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int OUT_N = 8;
    localparam int FB_W = 18;
    localparam int POST_W = 4;
    localparam int GAIN_W = 2;
    // Register offsets.
    localparam logic [3:0] OFF_OUTPUT_CTRL = 4'h0;
    localparam logic [3:0] OFF_FEEDBACK = 4'h1;
    localparam logic [3:0] OFF_STATUS = 4'h2;
    localparam logic [3:0] OFF_DIVISION = 4'h3;
    // Output control word fields.
    localparam int POS_PER_EN = 0;
    localparam int POS_GLOBAL_EN = 8;
    localparam int POS_TAP_EN = 9;
    // Feedback configuration word fields.
    localparam int POS_FB_DIV = 0;
    localparam int POS_POST_DIV = 18;
    localparam int POS_GAIN = 22;
    // Status word fields.
    localparam int POS_ST_CAL = 0;
    localparam int POS_ST_FB_BAD = 1;
    localparam int POS_ST_POST_BAD = 2;
    localparam int POS_ST_GATE = 3;
    // Reset values and divider limits.
    localparam logic GLOBAL_EN_RST = 1'b1;
    localparam logic TAP_EN_RST = 1'b0;
    localparam logic [7:0] PER_EN_RST = 8'h00;
    localparam logic [17:0] FB_DIV_RST = 18'h002f8;
    localparam logic [3:0] POST_DIV_RST = 4'h2;
    localparam logic [1:0] GAIN_RST = 2'h0;
    localparam logic [3:0] POST_DIV_MIN = 4'h2;
    localparam logic [3:0] POST_DIV_MAX = 4'h8;
    localparam logic [17:0] FB_DIV_ZERO = 18'h00000;
    // Pump gain codes and multipliers.
    localparam logic [1:0] GAIN_X1 = 2'h0;
    localparam logic [1:0] GAIN_X4 = 2'h1;
    localparam logic [1:0] GAIN_X16 = 2'h2;
    localparam logic [5:0] MULT_X1 = 6'h01;
    localparam logic [5:0] MULT_X4 = 6'h04;
    localparam logic [5:0] MULT_X16 = 6'h10;
    localparam logic [5:0] MULT_X32 = 6'h20;
    // Calibration busy time.
    localparam int CAL_TIME_NS = 1000;
    localparam int CLK_PERIOD_NS = 4;
    localparam int CAL_CYCLES = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

/* File: pin_sync.sv */
// Purpose: Two-stage synchroniser for one asynchronous pin.
// Assumes: The pin is a slow level.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/10ps
`default_nettype none
module pin_sync (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic pin_async,
    output logic pin_sync_q
);
    logic meta_q;
    logic meta_d;
    logic sync_d;
    always_comb begin
        meta_d = pin_async;
        sync_d = meta_q;
    end
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            meta_q <= 1'b0;
            pin_sync_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            pin_sync_q <= sync_d;
        end
    end
endmodule // pin_sync
`default_nettype wire

/* File: cal_timer.sv */
// Purpose: Frequency calibration busy timer.
// Assumes: A one-cycle start pulse.
// Notes: A new start during a run restarts the count.
`timescale 1ns/10ps
`default_nettype none
module cal_timer #(
    parameter int CYCLES = pll_cfg_pkg::CAL_CYCLES
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic start,
    output logic busy_q
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(CYCLES);
    localparam logic [CW-1:0] ONE = CW'(1);
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic busy_d;
    always_comb begin
        cnt_d = cnt_q;
        if (start) begin
            cnt_d = LOAD;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - ONE;
        end
        busy_d = (cnt_d != '0);
    end
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cnt_q <= '0;
            busy_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            busy_q <= busy_d;
        end
    end
endmodule // cal_timer
`default_nettype wire

/* File: pll_cfg_sva.sv */
// Purpose: Port checker for the PLL and output configuration decode.
// Assumes: One clock, synchronous active-high reset.
// Notes: Sees only the ports of the decode block.
`timescale 1ns/10ps
`default_nettype none
module pll_cfg_sva #(
    parameter int OUT_N = 8,
    parameter int CAL_CYCLES = 250
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic global_output_gate_pin,
    input wire logic [OUT_N-1:0] clock_output_en,
    input wire logic vco_tap_en,
    input wire logic [17:0] feedback_div,
    input wire logic [3:0] post_div,
    input wire logic [21:0] total_feedback_div,
    input wire logic [5:0] pump_gain_mult,
    input wire logic cal_start,
    input wire logic cal_busy
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    logic wr_fb;
    logic wr_ctl;
    assign wr_fb = reg_write && reg_addr == pll_cfg_pkg::OFF_FEEDBACK;
    assign wr_ctl = reg_write && reg_addr == pll_cfg_pkg::OFF_OUTPUT_CTRL;
    function automatic logic [5:0] gain_of(input logic [1:0] c);
        return (c == 2'h3) ? 6'h20 : 6'h01 << (2 * c);
    endfunction
    glob_off_a: assert property (wr_ctl && !reg_wdata[8] |=>
        clock_output_en == '0) else $error("outputs on, global off");
    tap_follow_a: assert property (wr_ctl |=>
        vco_tap_en == $past(reg_wdata[9])) else $error("tap enable wrong");
    cal_kick_a: assert property (wr_fb |=> cal_start ##1 cal_busy)
        else $error("calibration not started");
    cal_cause_a: assert property (cal_start |-> $past(wr_fb))
        else $error("stray calibration start");
    total_prod_a: assert property (
        total_feedback_div == feedback_div * post_div)
        else $error("total division wrong");
    post_range_a: assert property (
        post_div >= 4'h2 && post_div <= 4'h8) else $error("post out of range");
    fb_valid_a: assert property (feedback_div != '0)
        else $error("feedback divider zero");
    gain_map_a: assert property (wr_fb |=>
        pump_gain_mult == gain_of($past(reg_wdata[23:22])))
        else $error("pump gain wrong");
    gate_off_a: assert property (!global_output_gate_pin [*4] |=>
        clock_output_en == '0) else $error("outputs on, gate low");
    hold_cfg_a: assert property (!wr_fb |=> $stable(feedback_div) &&
        $stable(post_div) && $stable(pump_gain_mult))
        else $error("divider moved without write");
    cover property (wr_fb ##1 cal_start ##1 cal_busy);
    cover property (wr_ctl && !reg_wdata[8]);
    cover property (!global_output_gate_pin [*4]);
endmodule // pll_cfg_sva
bind pll_output_config_decode pll_cfg_sva #(.OUT_N(OUT_N),
    .CAL_CYCLES(CAL_CYCLES)) sva_i (.sys_clk, .srst, .reg_addr,
    .reg_wdata, .reg_write, .reg_read, .reg_rdata, .global_output_gate_pin,
    .clock_output_en, .vco_tap_en, .feedback_div, .post_div,
    .total_feedback_div, .pump_gain_mult, .cal_start, .cal_busy);
`default_nettype wire

/* File: cfg_host.sv */
// Purpose: Host model writing configuration words.
// Assumes: Read data stands the cycle after the read strobe.
// Notes: Invalid codes go out only when a test passes them.
`timescale 1ns/10ps
`default_nettype none
module cfg_host (
    input wire logic sys_clk,
    output logic [3:0] reg_addr,
    output logic [31:0] reg_wdata,
    output logic reg_write,
    output logic reg_read,
    input wire logic [31:0] reg_rdata
);
    initial begin
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        reg_write = 1'b0;
        reg_read = 1'b0;
    end
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge sys_clk);
        reg_write <= 1'b0;
        // Stale data would hide a late sample, so it is inverted.
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask
endmodule // cfg_host
`default_nettype wire

/* File: pll_output_config_decode_bench.sv */
// Purpose: Self-checking bench for the configuration decode.
// Assumes: Short calibration count for run time.
// Notes: Expected values come from a model held in integers.
`timescale 1ns/10ps
`default_nettype none
module pll_output_config_decode_bench;
    localparam int CALN = 4;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic gate = 1'b1;
    logic reg_write, reg_read, vco_tap_en, cal_start, cal_busy;
    logic [3:0] reg_addr, post_div;
    logic [31:0] reg_wdata, reg_rdata, r;
    logic [7:0] clock_output_en;
    logic [17:0] feedback_div;
    logic [21:0] total_feedback_div;
    logic [5:0] pump_gain_mult;
    int num_errors = 0;
    int checked = 0;
    int pen = 0, glob = 1, tap = 0, efb = 760, epd = 2, mult = 1, n;
    int gt[4] = '{1, 4, 16, 32};
    bit bf = 0, bp = 0;
    always #2 sys_clk = ~sys_clk;
    cfg_host host (.sys_clk, .reg_addr, .reg_wdata, .reg_write, .reg_read,
        .reg_rdata);
    pll_output_config_decode #(.CAL_CYCLES(CALN)) uut (.sys_clk, .srst,
        .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .global_output_gate_pin(gate), .clock_output_en, .vco_tap_en,
        .feedback_div, .post_div, .total_feedback_div, .pump_gain_mult,
        .cal_start, .cal_busy);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic outs();
        chk(clock_output_en, (glob && gate) ? pen : 0);
        chk(vco_tap_en, tap);
        chk(feedback_div, efb);
        chk(post_div, epd);
        chk(total_feedback_div, efb * epd);
        chk(pump_gain_mult, mult);
        host.rd(pll_cfg_pkg::OFF_STATUS, r);
        chk(r[3:0], {gate, bp, bf, 1'b0});
        host.rd(pll_cfg_pkg::OFF_DIVISION, r);
        chk(r, efb * epd);
    endtask
    task automatic ctrl(input logic [31:0] d);
        host.wr(pll_cfg_pkg::OFF_OUTPUT_CTRL, d);
        pen = d[7:0];
        glob = d[8];
        tap = d[9];
        #1 chk(reg_rdata, 32'h0);
        outs();
    endtask
    task automatic feed(input int f, input int p, input int g);
        logic [31:0] d;
        d = {8'h00, g[1:0], p[3:0], f[17:0]};
        host.wr(pll_cfg_pkg::OFF_FEEDBACK, d);
        #1 chk(cal_start, 1'b1);
        bf = f == 0;
        bp = p < 2 || p > 8;
        if (!bf) efb = f;
        if (!bp) epd = p;
        mult = gt[g];
        host.rd(pll_cfg_pkg::OFF_STATUS, r);
        chk(r[0], 1'b1);
        chk(cal_start, 1'b0);
        chk(cal_busy, 1'b1);
        // The status read above already spent the first busy cycle.
        n = 1;
        while (cal_busy === 1'b1 && n < 300) begin
            n++;
            @(posedge sys_clk);
            #1;
        end
        chk(n, CALN);
        host.rd(pll_cfg_pkg::OFF_FEEDBACK, r);
        chk(r, d);
        outs();
    endtask
    task automatic conclude();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #100000;
        num_errors++;
        conclude();
    end
    initial begin
        n = $urandom(70442);
        repeat (20) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        #1 outs();
        host.rd(pll_cfg_pkg::OFF_OUTPUT_CTRL, r);
        chk(r[9:0], 10'h100);
        for (int i = 0; i < 16; i++) begin
            @(posedge sys_clk);
            gate <= ($urandom % 4) != 0;
            repeat (3) @(posedge sys_clk);
            ctrl($urandom);
            feed($urandom % 262143 + 1, $urandom % 7 + 2, i % 4);
        end
        // Edge values of both dividers, then codes the host must avoid.
        feed(1, 8, 3);
        feed(262143, 2, 0);
        feed(0, 5, 1);
        feed(9, 0, 2);
        feed(100, 1, 0);
        feed(100, 15, 0);
        feed(100, 9, 1);
        host.wr(4'hf, 32'hffffffff);
        host.wr(pll_cfg_pkg::OFF_STATUS, 32'hffffffff);
        host.wr(pll_cfg_pkg::OFF_DIVISION, 32'h0);
        #1 outs();
        host.rd(4'hf, r);
        chk(r, 32'h0);
        // A reset in mid-run must bring every field back to its default.
        @(posedge sys_clk);
        srst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        srst <= 1'b0;
        pen = 0;
        glob = 1;
        tap = 0;
        efb = 760;
        epd = 2;
        mult = 1;
        bf = 0;
        bp = 0;
        @(posedge sys_clk);
        #1 chk(cal_busy, 1'b0);
        outs();
        host.rd(pll_cfg_pkg::OFF_OUTPUT_CTRL, r);
        chk(r, 32'h100);
        host.rd(pll_cfg_pkg::OFF_FEEDBACK, r);
        chk(r, {8'h00, pll_cfg_pkg::GAIN_RST, pll_cfg_pkg::POST_DIV_RST,
            pll_cfg_pkg::FB_DIV_RST});
        conclude();
    end
endmodule // pll_output_config_decode_bench
`default_nettype wire
